/* ubrg_top.sv */
// Purpose: Bit-rate generator with 16-bit divisor and majority-voted receive line.
// Assumes: Single clock; software programs it over AXI4-Lite.
// Notes: One tick every prescale*(n+1) enabled clocks; ce low freezes all state.
`include "ubrg_params.svh"
`default_nettype none

// Behaviour
// - Rate timing counts the device clock, so rate tracks clock frequency.
// - Receive pin sampled three times; majority of samples gives the line level.
// - Async, 8-bit divider, low speed: divide by 64 times (n+1).
// - Async, 16-bit divider, low speed: divide by 16 times (n+1).
// - Sync mode: divide by 4 times (n+1), 8-bit or 16-bit divider.
// - Sync mode ignores high-speed select; wide select alone picks width.
// - Divisor n is high byte above low byte.
// - Wide select clear uses only the low byte; set uses all 16 bits.
// - Writing either divisor byte clears the timer at once.
module ubrg_top
  import ubrg_pkg::*;
(
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write channels
  input wire logic [`UBRG_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [`UBRG_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial line and generator outputs
  input wire logic receive_pin,
  output logic rate_tick,
  output logic rx_level
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  ubrg_byte_t transmit_control_q, receive_control_q, rate_control_q;
  ubrg_byte_t divisor_high_byte_q, divisor_low_byte_q;
  logic awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [5:0] pre_q;
  logic [15:0] cnt_q;
  logic rate_tick_q, rx_level_q;
  logic rx_meta_q, rx_sync_q;
  logic [2:0] rx_samp_q;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire wr_fire = ce && s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
  wire wr_lane = s_axi_wstrb[0];
  wire wr_tx = s_axi_awaddr == `UBRG_OFS_TXCTL;
  wire wr_rx = s_axi_awaddr == `UBRG_OFS_RXCTL;
  wire wr_rc = s_axi_awaddr == `UBRG_OFS_RATECTL;
  wire wr_hi = s_axi_awaddr == `UBRG_OFS_DIVHI;
  wire wr_lo = s_axi_awaddr == `UBRG_OFS_DIVLO;
  wire wr_hit = wr_tx || wr_rx || wr_rc || wr_hi || wr_lo;
  wire div_write = wr_fire && wr_lane && (wr_hi || wr_lo);
  wire rd_fire = ce && s_axi_arvalid && !arready_q && !rvalid_q;
  wire rd_tx = s_axi_araddr == `UBRG_OFS_TXCTL;
  wire rd_rx = s_axi_araddr == `UBRG_OFS_RXCTL;
  wire rd_rc = s_axi_araddr == `UBRG_OFS_RATECTL;
  wire rd_hi = s_axi_araddr == `UBRG_OFS_DIVHI;
  wire rd_lo = s_axi_araddr == `UBRG_OFS_DIVLO;
  wire rd_st = s_axi_araddr == `UBRG_OFS_STATUS;
  wire rd_hit = rd_tx || rd_rx || rd_rc || rd_hi || rd_lo || rd_st;
  wire [7:0] status_w = (8'(rx_level_q) << `UBRG_BIT_RXLVL) | (8'(rate_tick_q) << `UBRG_BIT_TICK);
  wire [7:0] rd_byte = rd_tx ? transmit_control_q : rd_rx ? receive_control_q :
                       rd_rc ? rate_control_q : rd_hi ? divisor_high_byte_q :
                       rd_lo ? divisor_low_byte_q : rd_st ? status_w : `UBRG_REG_RST;

  // ----------------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------------
  wire sync_mode = transmit_control_q[`UBRG_BIT_SYNC];
  wire high_speed_select = transmit_control_q[`UBRG_BIT_HIGH];
  wire wide_divider_select = rate_control_q[`UBRG_BIT_WIDE];
  // High speed only matters in async mode; sync always divides by four.
  wire ubrg_div_t div_sel = sync_mode ? ubrg_div4 :
    (wide_divider_select && high_speed_select) ? ubrg_div4 :
    (wide_divider_select || high_speed_select) ? ubrg_div16 : ubrg_div64;
  logic [5:0] pre_max;
  always_comb
  begin
    case (div_sel)
      ubrg_div64: pre_max = `UBRG_PRE_MAX64;
      ubrg_div16: pre_max = `UBRG_PRE_MAX16;
      ubrg_div4: pre_max = `UBRG_PRE_MAX4;
      default: pre_max = `UBRG_PRE_MAX64;
    endcase
  end
  wire [15:0] n_eff = wide_divider_select ? {divisor_high_byte_q, divisor_low_byte_q}
                                          : {8'h00, divisor_low_byte_q};
  wire pre_wrap = pre_q >= pre_max;
  // Compare with >= so a divisor cut below the running count wraps at the next prescaler wrap.
  wire cnt_wrap = pre_wrap && (cnt_q >= n_eff);
  wire rx_maj = (rx_samp_q[0] & rx_samp_q[1]) | (rx_samp_q[1] & rx_samp_q[2]) |
                (rx_samp_q[0] & rx_samp_q[2]);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      transmit_control_q <= `UBRG_REG_RST;
      receive_control_q <= `UBRG_REG_RST;
      rate_control_q <= `UBRG_REG_RST;
      divisor_high_byte_q <= `UBRG_REG_RST;
      divisor_low_byte_q <= `UBRG_REG_RST;
    end
    else if (wr_fire && wr_lane)
    begin
      if (wr_tx) transmit_control_q <= s_axi_wdata[7:0];
      if (wr_rx) receive_control_q <= s_axi_wdata[7:0];
      if (wr_rc) rate_control_q <= s_axi_wdata[7:0] & `UBRG_RATECTL_MASK;
      if (wr_hi) divisor_high_byte_q <= s_axi_wdata[7:0];
      if (wr_lo) divisor_low_byte_q <= s_axi_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `UBRG_RESP_OKAY;
    end
    else if (ce)
    begin
      awready_q <= wr_fire;
      if (wr_fire) bresp_q <= wr_hit ? `UBRG_RESP_OKAY : `UBRG_RESP_SLVERR;
      // The response may only follow the address and data handshakes, so it waits one cycle.
      if (awready_q) bvalid_q <= 1'b1;
      else if (s_axi_bready) bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `UBRG_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      arready_q <= rd_fire;
      if (rd_fire)
      begin
        rresp_q <= rd_hit ? `UBRG_RESP_OKAY : `UBRG_RESP_SLVERR;
        rdata_q <= {24'h000000, rd_byte};
      end
      if (arready_q) rvalid_q <= 1'b1;
      else if (s_axi_rready) rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Rate timer
  // ----------------------------------------------------------------------
  // The timer counts enabled device clocks only, so the rate scales with it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_q <= 6'h00;
      cnt_q <= 16'h0000;
      rate_tick_q <= 1'b0;
    end
    else if (ce)
    begin
      rate_tick_q <= cnt_wrap && !div_write;
      if (div_write || pre_wrap) pre_q <= 6'h00;
      else pre_q <= pre_q + 6'h01;
      if (div_write || cnt_wrap) cnt_q <= 16'h0000;
      else if (pre_wrap) cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Receive line majority detect
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_samp_q <= 3'h7;
      rx_level_q <= 1'b1;
    end
    else if (ce)
    begin
      rx_meta_q <= receive_pin;
      rx_sync_q <= rx_meta_q;
      rx_samp_q <= {rx_samp_q[1:0], rx_sync_q};
      rx_level_q <= rx_maj;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign rate_tick = rate_tick_q;
  assign rx_level = rx_level_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Gap between ticks in enabled cycles; only trusted after a tick with no write since.
  logic [22:0] gap_q;
  logic stable_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap_q <= 23'h000000;
      stable_q <= 1'b0;
    end
    else if (ce)
    begin
      gap_q <= rate_tick_q ? 23'h000001 : gap_q + 23'h000001;
      if (wr_fire) stable_q <= 1'b0;
      else if (rate_tick_q) stable_q <= 1'b1;
    end
  end
  wire [22:0] n1 = {7'h00, n_eff} + 23'h000001;
  wire tick_ok = rate_tick_q && ce && stable_q && !wr_fire;
  wire [1:0] rx_ones = 2'(rx_samp_q[0]) + 2'(rx_samp_q[1]) + 2'(rx_samp_q[2]);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_async_low_narrow: assert property (tick_ok && !sync_mode && !wide_divider_select && !high_speed_select
    |-> gap_q == 23'(n1 * 23'({17'h0, `UBRG_PRE_MAX64} + 23'h1))) else $error("Divide by 64 period wrong.");
  chk_async_low_wide: assert property (tick_ok && !sync_mode && wide_divider_select && !high_speed_select
    |-> gap_q == 23'(n1 * 23'({17'h0, `UBRG_PRE_MAX16} + 23'h1))) else $error("Wide low-speed period wrong.");
  chk_sync_period: assert property (tick_ok && sync_mode
    |-> gap_q == 23'(n1 * 23'({17'h0, `UBRG_PRE_MAX4} + 23'h1))) else $error("Sync period wrong.");
  chk_async_high_speed: assert property (tick_ok && !sync_mode && high_speed_select
    |-> gap_q == 23'(n1 * (wide_divider_select ? 23'({17'h0, `UBRG_PRE_MAX4} + 23'h1)
                                              : 23'({17'h0, `UBRG_PRE_MAX16} + 23'h1))))
    else $error("High-speed period wrong.");
  chk_sync_ignores_high: assert property (sync_mode |-> pre_max == `UBRG_PRE_MAX4)
    else $error("Sync mode used high-speed select.");
  chk_divisor_join: assert property (wide_divider_select |-> n_eff == {divisor_high_byte_q, divisor_low_byte_q})
    else $error("Divisor bytes joined wrongly.");
  chk_narrow_ignores_high: assert property (!wide_divider_select |-> n_eff[15:8] == 8'h00)
    else $error("Narrow divider used high byte.");
  chk_write_clears_timer: assert property (div_write |=> pre_q == 6'h00 && cnt_q == 16'h0000 && !rate_tick_q)
    else $error("Divisor write did not clear timer.");
  chk_majority_vote: assert property (ce |=> rx_level_q == ($past(rx_ones) >= 2'h2))
    else $error("Line level is not the sample majority.");
  chk_timer_frozen: assert property (!ce |=> $stable(pre_q) && $stable(cnt_q))
    else $error("Timer moved without clock enable.");

  cov_async_tick: cover property (tick_ok && !sync_mode);
  cov_sync_tick: cover property (tick_ok && sync_mode);
  cov_div_write: cover property (div_write ##[1:300] rate_tick_q);
  cov_rx_low: cover property (rx_level_q ##1 !rx_level_q);

endmodule // ubrg_top
`default_nettype wire

/* ubrg_params.svh */
// Purpose: Constants for the rate generator and receive-line sampler.
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in the low byte lanes.
// Notes: Offsets are byte addresses, one aligned word per register.
`ifndef UBRG_PARAMS_SVH
`define UBRG_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define UBRG_AW 8
`define UBRG_OFS_TXCTL 8'h00
`define UBRG_OFS_RXCTL 8'h04
`define UBRG_OFS_RATECTL 8'h08
`define UBRG_OFS_DIVHI 8'h0C
`define UBRG_OFS_DIVLO 8'h10
`define UBRG_OFS_STATUS 8'h14
`define UBRG_REG_RST 8'h00
`define UBRG_RATECTL_MASK 8'hDB

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UBRG_BIT_SYNC 4
`define UBRG_BIT_HIGH 2
`define UBRG_BIT_WIDE 3
`define UBRG_BIT_RXLVL 0
`define UBRG_BIT_TICK 1

// ----------------------------------------------------------------------
// Prescaler terminal counts and bus answers
// ----------------------------------------------------------------------
`define UBRG_PRE_MAX64 6'h3F
`define UBRG_PRE_MAX16 6'h0F
`define UBRG_PRE_MAX4 6'h03
`define UBRG_RESP_OKAY 2'h0
`define UBRG_RESP_SLVERR 2'h2

`endif

/* ubrg_pkg.sv */
// Purpose: Types shared by the rate generator.
// Assumes: Constants come from ubrg_params.svh.
// Notes: The divide-factor selection is kept as an enumeration.
`default_nettype none
package ubrg_pkg;
  typedef enum logic [1:0] {
    ubrg_div64 = 2'b00,
    ubrg_div16 = 2'b01,
    ubrg_div4 = 2'b10
  } ubrg_div_t;
  typedef logic [7:0] ubrg_byte_t;
endpackage
`default_nettype wire

/* ubrg_testbench.sv */
// Purpose: Self-checking bench for the rate generator and the receive-line sampler.
// Assumes: Registered AXI4-Lite answers; ce held high except for one 10-cycle freeze in the clock-enable test.
// Notes: Periods are measured from tick to tick, so the phase of the timer does not matter.
`include "ubrg_params.svh"
`default_nettype none
module testbench
  import ubrg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, receive_pin;
  logic awready, wready, bvalid, arready, rvalid, rate_tick, rx_level;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int compares = 0;
  int cyc;

  ubrg_top DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .receive_pin(receive_pin), .rate_tick(rate_tick), .rx_level(rx_level)
  );

  // ----------------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A wait that runs out is reported as a mismatch and ends the run.
  task automatic fail_wait();
    check(32'h0, 32'h1);
    print_verdict();
  endtask

  task automatic reg_write(input logic [7:0] a, input ubrg_byte_t d, input logic [1:0] exp_resp);
    int i;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    if (i == 20)
      fail_wait();
    check({30'h0, bresp}, {30'h0, exp_resp});
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [1:0] exp_resp, output logic [31:0] d);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    if (i == 20)
      fail_wait();
    d = rdata;
    check({30'h0, rresp}, {30'h0, exp_resp});
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic read_check(input logic [7:0] a, input ubrg_byte_t exp);
    logic [31:0] d;
    reg_read(a, `UBRG_RESP_OKAY, d);
    check(d, {24'h0, exp});
  endtask

  task automatic wait_tick(output int n);
    for (n = 1; n <= 5000; n++)
    begin
      @(posedge aclk);
      if (rate_tick === 1'b1)
        return;
    end
    fail_wait();
  endtask

  task automatic run_case(input ubrg_byte_t tx, input ubrg_byte_t rc, input ubrg_byte_t hi,
                          input ubrg_byte_t lo, input int period);
    reg_write(`UBRG_OFS_TXCTL, tx, `UBRG_RESP_OKAY);
    reg_write(`UBRG_OFS_RATECTL, rc, `UBRG_RESP_OKAY);
    reg_write(`UBRG_OFS_DIVHI, hi, `UBRG_RESP_OKAY);
    reg_write(`UBRG_OFS_DIVLO, lo, `UBRG_RESP_OKAY);
    wait_tick(cyc);
    wait_tick(cyc);
    check(cyc, period);
  endtask

  // ----------------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    receive_pin = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, then write and read back every writable register.
    for (int k = 0; k < 5; k++) read_check(8'(k * 4), 8'h00);
    for (int k = 0; k < 5; k++) reg_write(8'(k * 4), 8'hA5, `UBRG_RESP_OKAY);
    for (int k = 0; k < 5; k++) read_check(8'(k * 4), (k == 2) ? (8'hA5 & `UBRG_RATECTL_MASK) : 8'hA5);
    wstrb <= 4'h0;
    reg_write(`UBRG_OFS_DIVLO, 8'h3C, `UBRG_RESP_OKAY);
    wstrb <= 4'hF;
    read_check(`UBRG_OFS_DIVLO, 8'hA5);
    reg_write(8'h18, 8'h77, `UBRG_RESP_SLVERR);
    reg_read(8'h18, `UBRG_RESP_SLVERR, rd);
    check(rd, 32'h0);
    // Divide factor for every mode; a stale high byte must not leak into the 8-bit divider.
    run_case(8'h00, 8'h00, 8'h01, 8'h02, 64 * (2 + 1));
    run_case(8'h04, 8'h00, 8'h01, 8'h02, 16 * (2 + 1));
    run_case(8'h00, 8'h08, 8'h01, 8'h02, 16 * (16'h0102 + 1));
    // Mid-count divisor write, as software retunes after a clock change: the new period applies at once.
    repeat (100) @(posedge aclk);
    reg_write(`UBRG_OFS_DIVHI, 8'h00, `UBRG_RESP_OKAY);
    wait_tick(cyc);
    check(32'((cyc >= 16 * 3 - 4) && (cyc <= 16 * 3 + 1)), 32'h1);
    run_case(8'h04, 8'h08, 8'h00, 8'h05, 4 * (5 + 1));
    run_case(8'h10, 8'h00, 8'h01, 8'h02, 4 * (2 + 1));
    run_case(8'h14, 8'h00, 8'h01, 8'h02, 4 * (2 + 1));
    run_case(8'h14, 8'h08, 8'h00, 8'h09, 4 * (9 + 1));
    // Frozen clock enable stands for a slower device clock: the period stretches by the frozen cycles.
    wait_tick(cyc);
    ce <= 1'b0;
    repeat (10) @(posedge aclk);
    ce <= 1'b1;
    wait_tick(cyc);
    check(cyc, 4 * (9 + 1));
    run_case(8'h10, 8'h08, 8'h01, 8'h00, 4 * (16'h0100 + 1));
    // A single low sample is outvoted; a held low level wins.
    receive_pin <= 1'b0;
    @(posedge aclk);
    receive_pin <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge aclk);
      check({31'h0, rx_level}, 32'h1);
    end
    receive_pin <= 1'b0;
    repeat (7) @(posedge aclk);
    check({31'h0, rx_level}, 32'h0);
    reg_read(`UBRG_OFS_STATUS, `UBRG_RESP_OKAY, rd);
    check(rd & 32'h1, 32'h0);
    // A second reset in mid-run returns the line level and the low divisor byte to their idle values.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({31'h0, rx_level}, 32'h1);
    read_check(`UBRG_OFS_DIVLO, 8'h00);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
